/* hw/wif_pkg.sv */
// wake and interrupt flag block: register map, field positions and reset values.
// assumes an 8-bit register port with a 16-bit byte address.
package wif_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int LINES_W = 7;

	// register byte addresses
	localparam logic [15:0] OFS_FLAGS = 16'h00E8;
	localparam logic [15:0] OFS_LINES = 16'h00F8;
	localparam logic [15:0] OFS_ENABLE = 16'h20B0;
	localparam logic [15:0] OFS_MASK = 16'h20B4;

	// flag register bit positions
	localparam int BIT_XFER = 0;
	localparam int BIT_RTC = 1;
	localparam int BIT_FWCOL0 = 2;
	localparam int BIT_FWCOL1 = 3;
	localparam int BIT_PB = 4;
	localparam int BIT_WAKE = 5;
	localparam int BIT_CK_RISE = 6;
	localparam int BIT_CK_FALL = 7;

	// enable register bit positions
	localparam int BIT_WD_EN = 0;
	localparam int BIT_SPI_EN = 4;

	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic RST_WD_EN = 1'b0;
	localparam logic RST_SPI_EN = 1'b0;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
endpackage

/* hw/wif_top.sv */
// wake and interrupt flag block: sticky wake/interrupt flags, masks, enables.
// assumes a single-cycle register port on i_core_clk; event inputs other than
// the pushbutton and clock-ok come from logic on the same clock as one-cycle pulses.
//
// Contract
// - pushbutton rising edge sets flag bit 4
// - low-power request clears pushbutton flag
// - pushbutton flag survives wake-up for boot
// - clock-ok rise sets bit 6, line four
// - clock-ok fall in battery mode sets bit 7
// - pushbutton wake into battery mode sets bit 7
// - autowake sets bit 5, readable at boot
// - transfer-busy sets bit 0, rtc bit 1
// - collision events set bits 2 and 3
// - line field reads live levels, no memory
// - enable bit 0 gates watchdog near-overflow
`timescale 1ns/1ps
module wif_top
(
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_pushbutton_input,
	input wire logic i_clock_ok,
	input wire logic i_battery_low_power_mode,
	input wire logic i_low_power_req,
	input wire logic i_wake_by_pushbutton,
	input wire logic i_autowake_event,
	input wire logic i_compute_transfer_busy,
	input wire logic i_rtc_event,
	input wire logic [1:0] i_fw_collision,
	input wire logic i_wd_near_overflow,
	input wire logic i_spi_event,
	input wire logic [6:0] i_irq_lines,
	output logic o_irq,
	output logic o_irq_line_four,
	output logic o_wd_near_overflow_irq,
	output logic o_spi_irq
);

	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [2:0] pb_sync_q;
	logic [2:0] ck_sync_q;
	logic pb_level_q;
	logic ck_level_q;
	logic pb_level_d;
	logic ck_level_d;
	logic pb_rise;
	logic ck_rise;
	logic ck_fall;

	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] mask_q;
	logic wd_en_q;
	logic spi_en_q;
	logic [7:0] rdata_d;

	wire sel_flags = (i_addr == wif_pkg::OFS_FLAGS);
	wire sel_lines = (i_addr == wif_pkg::OFS_LINES);
	wire sel_enable = (i_addr == wif_pkg::OFS_ENABLE);
	wire sel_mask = (i_addr == wif_pkg::OFS_MASK);
	wire wr_flags = i_wr & sel_flags;
	wire wr_enable = i_wr & sel_enable;
	wire wr_mask = i_wr & sel_mask;

	// a synchronised level moves only once stages two and three agree
	function automatic logic agreed_level(input logic [2:0] stages, input logic held);
		agreed_level = (stages[1] == stages[2]) ? stages[2] : held;
	endfunction

	function automatic logic [7:0] field_at(input logic v, input int pos);
		field_at = 8'h00;
		field_at[pos] = v;
	endfunction

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pb_sync_q <= 3'h0;
			ck_sync_q <= 3'h0;
			pb_level_q <= 1'b0;
			ck_level_q <= 1'b0;
		end
		else
		begin
			pb_sync_q <= {pb_sync_q[1:0], i_pushbutton_input};
			ck_sync_q <= {ck_sync_q[1:0], i_clock_ok};
			pb_level_q <= pb_level_d;
			ck_level_q <= ck_level_d;
		end
	end

	// only stages two and three are looked at; stage one feeds stage two alone
	assign pb_level_d = agreed_level(pb_sync_q, pb_level_q);
	assign ck_level_d = agreed_level(ck_sync_q, ck_level_q);
	assign pb_rise = pb_level_d & ~pb_level_q;
	assign ck_rise = ck_level_d & ~ck_level_q;
	assign ck_fall = ~ck_level_d & ck_level_q;

	// hardware set sources, one per flag bit except bit 7, which has two
	always_comb
	begin
		flag_set = 8'h00;
		flag_set[wif_pkg::BIT_XFER] = i_compute_transfer_busy;
		flag_set[wif_pkg::BIT_RTC] = i_rtc_event;
		flag_set[wif_pkg::BIT_FWCOL0] = i_fw_collision[0];
		flag_set[wif_pkg::BIT_FWCOL1] = i_fw_collision[1];
		flag_set[wif_pkg::BIT_PB] = pb_rise;
		flag_set[wif_pkg::BIT_WAKE] = i_autowake_event;
		flag_set[wif_pkg::BIT_CK_RISE] = ck_rise;
		// a fall only counts as a low-power entry when battery mode is on in the same cycle
		flag_set[wif_pkg::BIT_CK_FALL] = i_battery_low_power_mode &
			(ck_fall | i_wake_by_pushbutton);
	end

	// a written zero clears, a written one leaves the flag alone; reads never clear
	always_comb
	begin
		flag_clr = wr_flags ? ~i_wdata : 8'h00;
		flag_clr[wif_pkg::BIT_PB] = flag_clr[wif_pkg::BIT_PB] | i_low_power_req;
	end

	// set beats clear so an event in the clearing cycle is not lost
	assign flags_d = flag_set | (flags_q & ~flag_clr);

	// no reset but the async one touches the flags, so wake-up keeps them for boot code
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			flags_q <= wif_pkg::RST_FLAGS;
		else
			flags_q <= flags_d;
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mask_q <= wif_pkg::RST_MASK;
			wd_en_q <= wif_pkg::RST_WD_EN;
			spi_en_q <= wif_pkg::RST_SPI_EN;
		end
		else
		begin
			if (wr_mask)
				mask_q <= i_wdata;
			if (wr_enable)
			begin
				wd_en_q <= i_wdata[wif_pkg::BIT_WD_EN];
				spi_en_q <= i_wdata[wif_pkg::BIT_SPI_EN];
			end
		end
	end

	wire [7:0] enable_view = field_at(wd_en_q, wif_pkg::BIT_WD_EN) |
		field_at(spi_en_q, wif_pkg::BIT_SPI_EN);

	// read mux; the line field is sampled straight from the lines, no holding state
	assign rdata_d = sel_flags ? flags_q :
		sel_lines ? {1'b0, i_irq_lines} :
		sel_enable ? enable_view :
		sel_mask ? mask_q :
		wif_pkg::RDATA_UNMAPPED;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 8'h00;
	end

	wire [7:0] pending = flags_q & mask_q;
	assign o_irq = |pending;
	assign o_irq_line_four = pending[wif_pkg::BIT_CK_RISE] | pending[wif_pkg::BIT_CK_FALL];
	assign o_wd_near_overflow_irq = wd_en_q & i_wd_near_overflow;
	assign o_spi_irq = spi_en_q & i_spi_event;

	// checks
	sequence s_pb_wake_batt;
		i_wake_by_pushbutton && i_battery_low_power_mode;
	endsequence

	sequence s_pb_fw_clear;
		wr_flags && !i_wdata[wif_pkg::BIT_PB] && !pb_rise;
	endsequence

	sequence s_rtc_held;
		i_rtc_event ##1 !wr_flags;
	endsequence

	sequence s_wd_armed;
		wr_enable && i_wdata[wif_pkg::BIT_WD_EN] ##1 i_wd_near_overflow;
	endsequence

	sequence s_rtc_masked;
		i_rtc_event && mask_q[wif_pkg::BIT_RTC] && !wr_mask;
	endsequence

	chk_pb_edge_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		pb_rise
		|=> flags_q[wif_pkg::BIT_PB])
		else $error("pushbutton edge did not set its flag");

	chk_pb_filter: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		pb_sync_q[1] != pb_sync_q[2]
		|=> pb_level_q == $past(pb_level_q))
		else $error("pushbutton level moved before its stages agreed");

	chk_pb_lowpower_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_low_power_req && !pb_rise
		|=> !flags_q[wif_pkg::BIT_PB])
		else $error("low-power request left pushbutton flag set");

	chk_pb_fw_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_pb_fw_clear
		|=> !flags_q[wif_pkg::BIT_PB])
		else $error("written zero left pushbutton flag set");

	chk_pb_flag_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!pb_rise && !i_low_power_req && !(wr_flags && !i_wdata[wif_pkg::BIT_PB])
		|=> flags_q[wif_pkg::BIT_PB] == $past(flags_q[wif_pkg::BIT_PB]))
		else $error("pushbutton flag changed without cause");

	chk_ck_filter: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		ck_sync_q[1] != ck_sync_q[2]
		|=> ck_level_q == $past(ck_level_q))
		else $error("clock-ok level moved before its stages agreed");

	chk_ck_rise_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		ck_rise
		|=> flags_q[wif_pkg::BIT_CK_RISE])
		else $error("clock-ok rise did not set its flag");

	chk_ck_rise_line4: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		ck_rise && mask_q[wif_pkg::BIT_CK_RISE] && !wr_mask
		|=> o_irq_line_four)
		else $error("clock-ok rise did not reach line four");

	chk_ck_fall_batt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		ck_fall && i_battery_low_power_mode
		|=> flags_q[wif_pkg::BIT_CK_FALL])
		else $error("clock-ok fall did not set its flag");

	chk_fall_line4: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		ck_fall && i_battery_low_power_mode && mask_q[wif_pkg::BIT_CK_FALL] && !wr_mask
		|=> o_irq_line_four)
		else $error("clock-ok fall did not reach line four");

	chk_fall_needs_batt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!i_battery_low_power_mode && !wr_flags
		|=> flags_q[wif_pkg::BIT_CK_FALL] == $past(flags_q[wif_pkg::BIT_CK_FALL]))
		else $error("fall flag moved outside battery mode");

	chk_pb_wake_fall: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_pb_wake_batt
		|=> flags_q[wif_pkg::BIT_CK_FALL])
		else $error("pushbutton wake into battery mode did not set fall flag");

	chk_autowake_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_autowake_event ##1 (!wr_flags) [*2]
		|-> flags_q[wif_pkg::BIT_WAKE])
		else $error("autowake flag lost before a clearing write");

	chk_autowake_kept: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		flags_q[wif_pkg::BIT_WAKE] && !wr_flags
		|=> flags_q[wif_pkg::BIT_WAKE])
		else $error("autowake flag dropped without a write");

	chk_hw_events_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		(i_compute_transfer_busy || i_rtc_event || |i_fw_collision)
		|=> ((flags_q[3:0] & $past(flag_set[3:0])) == $past(flag_set[3:0])))
		else $error("event did not set its flag");

	chk_xfer_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_compute_transfer_busy
		|=> flags_q[wif_pkg::BIT_XFER])
		else $error("transfer event did not set its flag");

	chk_rtc_held: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_rtc_held
		|=> flags_q[wif_pkg::BIT_RTC])
		else $error("rtc flag lost without a write");

	chk_fwcol_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_fw_collision[1]
		|=> flags_q[wif_pkg::BIT_FWCOL1])
		else $error("second collision event did not set its flag");

	chk_lines_live: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_rd && sel_lines
		|=> o_rdata == {1'b0, $past(i_irq_lines)})
		else $error("line field did not show live levels");

	chk_wd_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_enable && !i_wdata[wif_pkg::BIT_WD_EN]
		|=> !o_wd_near_overflow_irq)
		else $error("watchdog interrupt passed while disabled");

	chk_wd_pass: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_wd_armed
		|-> o_wd_near_overflow_irq)
		else $error("watchdog interrupt blocked while enabled");

	chk_enable_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_enable
		|=> wd_en_q == $past(i_wdata[wif_pkg::BIT_WD_EN]) && spi_en_q == $past(i_wdata[wif_pkg::BIT_SPI_EN]))
		else $error("enable write did not land");

	chk_enable_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!wr_enable
		|=> $stable(wd_en_q) && $stable(spi_en_q))
		else $error("enable bits changed without a write");

	chk_spi_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_enable && !i_wdata[wif_pkg::BIT_SPI_EN]
		|=> !o_spi_irq)
		else $error("spi interrupt passed while disabled");

	chk_one_keeps: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_flags && i_wdata == 8'hFF && !i_low_power_req
		|=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("writing ones cleared a flag");

	chk_irq_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_mask && i_wdata == 8'h00
		|=> !o_irq)
		else $error("interrupt raised with every flag masked");

	chk_irq_raise: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_rtc_masked
		|=> o_irq)
		else $error("enabled flag did not raise the interrupt");

	chk_mask_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_mask
		|=> mask_q == $past(i_wdata))
		else $error("mask write did not land");

	chk_mask_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!wr_mask
		|=> $stable(mask_q))
		else $error("mask changed without a write");

	chk_rdata_flags: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_rd && sel_flags
		|=> o_rdata == $past(flags_q))
		else $error("flag read returned wrong data");

	chk_rdata_mask: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_rd && sel_mask
		|=> o_rdata == $past(mask_q))
		else $error("mask read returned wrong data");

	chk_rdata_unmapped: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_rd && !sel_flags && !sel_lines && !sel_enable && !sel_mask
		|=> o_rdata == wif_pkg::RDATA_UNMAPPED)
		else $error("unmapped read returned data");

	chk_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!i_rd
		|=> o_rdata == 8'h00)
		else $error("read data stood without a read");

	chk_read_keeps: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_rd && sel_flags && !i_wr && !i_low_power_req
		|=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("reading the flags cleared one");

endmodule

/* verification/wif_mpu.sv */
// firmware model: owns the register port and does reads, writes and flag clears.
// assumes a slave that never stalls, with read data only in the cycle after the strobe.
`timescale 1ns/1ps
module wif_mpu
(
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic [15:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial
	begin
		o_addr = 16'h0000;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// callers enter just after an edge; the strobe is held to the next one
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
	// a zero clears its flag, the ones leave the other flags alone
	task automatic clr(input int b);
		wr(wif_pkg::OFS_FLAGS, ~(8'h01 << b));
	endtask
endmodule

/* verification/wif_top_tb.sv */
// bench for the flag block: register reads and writes, events, pins and enables.
// assumes the firmware model drives the register port; event inputs on ev are one-cycle pulses, wd and spi are held levels.
`timescale 1ns/1ps
module wif_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic button = 1'b0;
	logic ck = 1'b0;
	logic bat = 1'b0;
	logic wd = 1'b0;
	logic spi = 1'b0;
	logic [7:0] ev = 8'h00;
	logic [6:0] lines = 7'h00;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic irq;
	logic irq4;
	logic wd_irq;
	logic spi_irq;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	initial
	begin
		forever #20 clk = ~clk;
	end
	wif_top wif_top_i
	(
		.i_core_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_pushbutton_input(button), .i_clock_ok(ck),
		.i_battery_low_power_mode(bat), .i_low_power_req(ev[4]), .i_wake_by_pushbutton(ev[7]),
		.i_autowake_event(ev[5]), .i_compute_transfer_busy(ev[0]), .i_rtc_event(ev[1]),
		.i_fw_collision(ev[3:2]), .i_wd_near_overflow(wd), .i_spi_event(spi),
		.i_irq_lines(lines), .o_irq(irq), .o_irq_line_four(irq4),
		.o_wd_near_overflow_irq(wd_irq), .o_spi_irq(spi_irq)
	);
	wif_mpu wif_mpu_i
	(
		.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
	);
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a hung wait ends the run as a failure
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_count++;
			summarize();
		end
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdc(string n, logic [15:0] a, logic [7:0] e);
		logic [7:0] v;
		wif_mpu_i.rd(a, v);
		chk(n, e, v);
	endtask
	task automatic pulse(logic [7:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
		@(posedge clk);
		#1;
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		rdc("flags", wif_pkg::OFS_FLAGS, wif_pkg::RST_FLAGS);
		rdc("mask", wif_pkg::OFS_MASK, wif_pkg::RST_MASK);
		rdc("enable", wif_pkg::OFS_ENABLE, 8'h00);
		rdc("unmapped", 16'h1234, wif_pkg::RDATA_UNMAPPED);
		$display("test reset done");
		for (int b = 0; b < 6; b++)
		begin
			if (b != 4)
			begin
				pulse(8'h01 << b);
				chk("irq masked", 8'h00, {7'h00, irq});
				wif_mpu_i.wr(wif_pkg::OFS_FLAGS, 8'hFF);
				rdc("flag set", wif_pkg::OFS_FLAGS, 8'h01 << b);
				wif_mpu_i.clr(b);
				rdc("flag clear", wif_pkg::OFS_FLAGS, 8'h00);
			end
		end
		$display("test events done");
		button <= 1'b1;
		ck <= 1'b1;
		settle();
		rdc("pin edges", wif_pkg::OFS_FLAGS, 8'h50);
		wif_mpu_i.wr(wif_pkg::OFS_MASK, 8'h40);
		chk("line four", 8'h03, {6'h00, irq4, irq});
		repeat (20) @(posedge clk);
		rdc("button kept", wif_pkg::OFS_FLAGS, 8'h50);
		pulse(8'h10);
		rdc("low power", wif_pkg::OFS_FLAGS, 8'h40);
		wif_mpu_i.clr(6);
		bat <= 1'b1;
		ck <= 1'b0;
		settle();
		rdc("clock fall", wif_pkg::OFS_FLAGS, 8'h80);
		wif_mpu_i.wr(wif_pkg::OFS_MASK, 8'h80);
		chk("fall line four", 8'h03, {6'h00, irq4, irq});
		wif_mpu_i.clr(7);
		chk("irq cleared", 8'h00, {6'h00, irq4, irq});
		bat <= 1'b0;
		pulse(8'h80);
		rdc("wake no battery", wif_pkg::OFS_FLAGS, 8'h00);
		bat <= 1'b1;
		pulse(8'h80);
		rdc("wake battery", wif_pkg::OFS_FLAGS, 8'h80);
		ev <= 8'h02;
		wif_mpu_i.wr(wif_pkg::OFS_FLAGS, 8'h7D);
		ev <= 8'h00;
		rdc("set wins", wif_pkg::OFS_FLAGS, 8'h02);
		$display("test pins done");
		wd <= 1'b1;
		spi <= 1'b1;
		lines <= 7'h55;
		settle();
		chk("enables off", 8'h00, {6'h00, wd_irq, spi_irq});
		wif_mpu_i.wr(wif_pkg::OFS_ENABLE, 8'h11);
		chk("enables on", 8'h03, {6'h00, wd_irq, spi_irq});
		rdc("enable", wif_pkg::OFS_ENABLE, 8'h11);
		rdc("lines", wif_pkg::OFS_LINES, 8'h55);
		lines <= 7'h2A;
		settle();
		rdc("lines", wif_pkg::OFS_LINES, 8'h2A);
		$display("test enables done");
		summarize();
	end
endmodule
